// [eeprom_two_wire_slave_port_tb.sv]
`default_nettype none
// ************************************************************
// Testbench of the two-wire slave port.
// ************************************************************
module eeprom_two_wire_slave_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] adr; logic [2:0] sel; logic ack;} etwsp_row_t;
   localparam etwsp_row_t ROWS [6] = '{'{8'hA0, 3'h0, 1'b0}, '{8'hA6, 3'h3, 1'b0},
      '{8'hAE, 3'h7, 1'b0}, '{8'h20, 3'h0, 1'b1}, '{8'hA2, 3'h0, 1'b1}, '{8'hA0, 3'h4, 1'b1}};
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       wp = 1'b0;
   logic [2:0] sel = 3'h0;
   logic [7:0] txd = 8'hC3;
   logic [7:0] rxd, last_rx, d;
   logic       scl, h_sda, sda_w, oe, sda_o, stb, radr, treq, stby, busy, a, last_ad;
   int         fail_count = 0;
   int         check_count = 0;
   int         cyc = 0;
   int         nstb = 0;
   // Open-drain wire with pull-up.
   // The wire follows the pin value only while enabled, so a high drive shows up.
   assign sda_w = h_sda & (~oe | sda_o);
   always #50 clk = ~clk;
   // Hang guard: the whole run needs under 8000 cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   // Memory side: keep the last strobed byte, swap read data per request.
   always @(negedge clk) begin
      if (stb === 1'b1) begin
         last_rx <= rxd;
         last_ad <= radr;
         nstb <= nstb + 1;
      end
      if (treq === 1'b1) txd <= txd ^ 8'h55;
   end
   // A write cycle of 200 clocks outlasts a whole polled address byte.
   etwsp_slave_port #(.P_TWR_US(20)) DUT (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_SCL(scl),
      .I_SDA(sda_w), .O_SDA_O(sda_o), .O_SDA_OE(oe), .I_HW_SEL(sel), .I_WP(wp),
      .O_RX_DATA(rxd), .O_RX_STB(stb), .O_RX_ADDR(radr), .O_TX_REQ(treq),
      .I_TX_DATA(txd), .O_STANDBY(stby), .O_WR_BUSY(busy));
   etwsp_host_model host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(h_sda));
   // Compare tasks for flags and bytes.
   task automatic chk1(input string n, input logic e, input logic s);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", n, e, s);
      end
   endtask
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Main sequence: address table first, then the awkward cases.
   initial begin
      repeat (6) @(negedge clk);
      chk1("standby", 1'b1, stby);
      chk1("sda_oe", 1'b0, oe);
      chk1("sda_o", 1'b0, sda_o);
      rstn = 1'b1;
      foreach (ROWS[k]) begin
         sel = ROWS[k].sel;
         repeat (4) @(negedge clk);
         host.start();
         host.put_byte(ROWS[k].adr, a);
         chk1("addr_ack", ROWS[k].ack, a);
         host.stop();
         chk1("standby", 1'b1, stby);
      end
      $display("test address table done");
      sel = 3'h5;
      host.start();
      host.put_byte(8'hAA, a);
      host.put_byte(8'h3C, a);
      chk8("word", 8'h3C, last_rx);
      chk1("word_flag", 1'b1, last_ad);
      for (int j = 0; j < 3; j++) begin
         host.put_byte(8'h5A + 8'(j), a);
         chk1("data_ack", 1'b0, a);
         chk8("data", 8'h5A + 8'(j), last_rx);
         chk1("data_flag", 1'b0, last_ad);
      end
      host.stop();
      chk1("wr_busy", 1'b1, busy);
      host.start();
      host.put_byte(8'hAA, a);
      chk1("busy_ack", 1'b1, a);
      host.stop();
      chk1("still_busy", 1'b1, busy);
      repeat (30) @(negedge clk);
      chk1("wr_done", 1'b0, busy);
      chk1("standby", 1'b1, stby);
      $display("test write done");
      wp = 1'b1;
      nstb = 0;
      host.start();
      host.put_byte(8'hAA, a);
      host.put_byte(8'h3C, a);
      host.put_byte(8'h77, a);
      chk1("wp_ack", 1'b0, a);
      host.stop();
      chk1("wp_busy", 1'b0, busy);
      chk8("wp_strobes", 8'h01, 8'(nstb));
      wp = 1'b0;
      $display("test protect done");
      host.start();
      host.put_byte(8'hAA, a);
      host.put_byte(8'h10, a);
      host.start();
      host.put_byte(8'hAB, a);
      chk1("rd_ack", 1'b0, a);
      host.get_byte(1'b0, d);
      chk8("rd0", 8'hC3 ^ 8'h55, d);
      host.get_byte(1'b1, d);
      chk8("rd1", 8'hC3, d);
      chk1("nack_oe", 1'b0, oe);
      chk1("nack_sb", 1'b1, stby);
      host.stop();
      $display("test read done");
      host.start();
      host.put_byte(8'hAA, a);
      host.recover();
      chk1("rec_sb", 1'b1, stby);
      host.start();
      host.put_byte(8'hAA, a);
      chk1("rec_ack", 1'b0, a);
      host.stop();
      $display("test recovery done");
      // Reset in mid-transfer with SCL low; the port must come back deaf.
      host.start();
      host.put_byte(8'hAA, a);
      rstn = 1'b0;
      repeat (3) @(negedge clk);
      chk1("rst_sb", 1'b1, stby);
      chk1("rst_oe", 1'b0, oe);
      rstn = 1'b1;
      host.stop();
      host.start();
      host.put_byte(8'hAA, a);
      chk1("rst_ack", 1'b0, a);
      host.stop();
      $display("test reset done");
      stop_test();
   end
endmodule
`default_nettype wire

// [etwsp_defines.svh]
// ************************************************************
// Constants of the two-wire slave port.
// ************************************************************
`ifndef ETWSP_DEFINES_SVH
`define ETWSP_DEFINES_SVH

// Fixed device type nibble in the upper bits of the address byte.
`define ETWSP_DEV_TYPE   4'hA
// Bits per byte before the response bit.
`define ETWSP_BITS       4'h8
// Byte position within a transfer, saturating at the data position.
`define ETWSP_IDX_ADDR   2'h0
`define ETWSP_IDX_WORD   2'h1
`define ETWSP_IDX_DATA   2'h2
// Width of the internal write-cycle timer.
`define ETWSP_TMR_W      24
// System clock period and unit conversion for timing figures.
`define ETWSP_TCLK_NS    100
`define ETWSP_NS_PER_US  1000
// Default internal write-cycle time in microseconds.
`define ETWSP_TWR_US     5000

`endif

// [etwsp_host_model.sv]
`default_nettype none
// ************************************************************
// Bus master model.
// ************************************************************
module etwsp_host_model (
   // Clock and wire level.
   input  wire logic i_clk,
   input  wire logic i_sda,
   // Master drive, high means released.
   output var  logic o_scl,
   output var  logic o_sda
);
   timeunit 1ns;
   timeprecision 1ns;
   // The bus idles high.
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // Quarter of an SCL period, well above the synchroniser delay.
   task automatic q();
      repeat (4) @(negedge i_clk);
   endtask
   // One clock: SDA moves only with SCL low, sampled mid high.
   task automatic bit_io(input logic b, output logic s);
      o_sda = b;
      q();
      o_scl = 1'b1;
      q();
      s = i_sda;
      q();
      o_scl = 1'b0;
      q();
   endtask
   // SDA falls while SCL is high; also serves as repeated start.
   task automatic start();
      o_sda = 1'b1;
      q();
      o_scl = 1'b1;
      q();
      o_sda = 1'b0;
      q();
      o_scl = 1'b0;
      q();
   endtask
   // SDA rises while SCL is high, then the bus idles.
   task automatic stop();
      o_sda = 1'b0;
      q();
      o_scl = 1'b1;
      q();
      o_sda = 1'b1;
      repeat (3) q();
   endtask
   // Eight bits without pause, then SDA released for the response.
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, ack);
   endtask
   // Eight bits read, then ACK or NACK driven by the master.
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nack, s);
   endtask
   // Bus recovery: start, nine clocks, start, stop.
   task automatic recover();
      logic s;
      start();
      repeat (9) bit_io(1'b1, s);
      start();
      stop();
   endtask
endmodule
`default_nettype wire

// [etwsp_line_if.sv]
`default_nettype none

// ************************************************************
// Bus events passed from the line monitor to the byte controller.
// ************************************************************
interface etwsp_line_if;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;
   logic       sda_bit;
   logic       wp_lvl;
   logic [2:0] sel;

   modport mon (output scl_rise, scl_fall, start_cond, stop_cond, sda_bit, wp_lvl, sel);
   modport ctl (input  scl_rise, scl_fall, start_cond, stop_cond, sda_bit, wp_lvl, sel);
endinterface

`default_nettype wire

// [etwsp_line_mon.sv]
`default_nettype none
`include "etwsp_defines.svh"

// ************************************************************
// Line monitor: pin synchronisers and start/stop detection.
// ************************************************************
module etwsp_line_mon (
   // Clock and reset.
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   // Raw pins.
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   input  wire logic       i_wp,
   input  wire logic [2:0] i_sel,
   // Events towards the controller.
   etwsp_line_if.mon       ln
);

   etwsp_pkg::etwsp_mon_t st_r;
   etwsp_pkg::etwsp_mon_t st_nxt;

   // Two flops per pin, then one delayed copy of SCL and SDA for edge detection.
   always_comb begin
      st_nxt       = st_r;
      st_nxt.scl_m = i_scl;
      st_nxt.scl_s = st_r.scl_m;
      st_nxt.scl_d = st_r.scl_s;
      st_nxt.sda_m = i_sda;
      st_nxt.sda_s = st_r.sda_m;
      st_nxt.sda_d = st_r.sda_s;
      st_nxt.wp_m  = i_wp;
      st_nxt.wp_s  = st_r.wp_m;
      st_nxt.sel_m = i_sel;
      st_nxt.sel_s = st_r.sel_m;
   end

   // Lines reset high, as an idle bus is, so release fakes no edge.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r       <= '0;
         st_r.scl_m <= 1'h1;
         st_r.scl_s <= 1'h1;
         st_r.scl_d <= 1'h1;
         st_r.sda_m <= 1'h1;
         st_r.sda_s <= 1'h1;
         st_r.sda_d <= 1'h1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Events come only from second-stage samples and their delayed copy.
   // SCL must be high in both samples, so an SDA move next to an SCL edge
   // is never taken for a condition.
   assign ln.scl_rise   = st_r.scl_s & ~st_r.scl_d;
   assign ln.scl_fall   = ~st_r.scl_s & st_r.scl_d;
   assign ln.start_cond = st_r.scl_s & st_r.scl_d & st_r.sda_d & ~st_r.sda_s;
   assign ln.stop_cond  = st_r.scl_s & st_r.scl_d & ~st_r.sda_d & st_r.sda_s;
   assign ln.sda_bit    = st_r.sda_s;
   assign ln.wp_lvl     = st_r.wp_s;
   assign ln.sel        = st_r.sel_s;

endmodule

`default_nettype wire

// [etwsp_pkg.sv]
`default_nettype none
`include "etwsp_defines.svh"

// ************************************************************
// Types shared by the line monitor and the byte controller.
// ************************************************************
package etwsp_pkg;

   // One-hot states of the byte controller.
   typedef enum logic [5:0] {
      ST_STANDBY = 6'h01,
      ST_RX      = 6'h02,
      ST_ACK     = 6'h04,
      ST_TX      = 6'h08,
      ST_TXACK   = 6'h10,
      ST_WRCYC   = 6'h20
   } etwsp_state_t;

   // State of the line monitor: synchronisers and one delayed sample.
   typedef struct packed {
      logic       scl_m;
      logic       scl_s;
      logic       scl_d;
      logic       sda_m;
      logic       sda_s;
      logic       sda_d;
      logic       wp_m;
      logic       wp_s;
      logic [2:0] sel_m;
      logic [2:0] sel_s;
   } etwsp_mon_t;

   // State of the byte controller.
   typedef struct packed {
      etwsp_state_t             state;
      logic [7:0]               shreg;
      logic [3:0]               bcnt;
      logic [1:0]               idx;
      logic                     rw;
      logic                     wr_pend;
      logic                     go;
      logic                     sda_oe;
      logic                     sda_o;
      logic [7:0]               rx_data;
      logic                     rx_stb;
      logic                     rx_addr;
      logic                     tx_req;
      logic                     idle;
      logic                     busy;
      logic [`ETWSP_TMR_W-1:0]  timer;
   } etwsp_ctl_t;

endpackage

`default_nettype wire

// [etwsp_slave_port.sv]
// Overview of operation
// - Sample SDA on SCL rising edge; change driven SDA only on falling edge.
// - Every byte moves most significant bit first, one bit per SCL cycle.
// - Each byte takes nine clocks: eight data bits, one response bit.
// - The SDA driver changes only while SCL is low, stable while high.
// - SDA falling while SCL high is a start; leave standby, receive a command.
// - Watch for a start except in the write cycle; before one, ignore the bus, never drive SDA.
// - SDA rising while SCL high is a stop; end transfer, return to standby, or enter the write cycle after written data.
// - A repeated start begins a fresh transfer without passing through standby.
// - No limit on the number of bytes between start and stop.
// - Transmitter releases SDA after the eighth clock; receiver holds low through ninth.
// - A high response to read data means stop sending and release SDA.
// - The acknowledging party releases SDA at the end of the ninth clock.
// - Standby after reset, plain stop, finished write cycle, or read no-acknowledge.
// - A mismatching device address byte sends the port to standby, no acknowledge.
// - After recovery any partial transfer is dropped and the port is idle.
// - While write protect is high, no data byte is written to the array.
// - Address byte: type nibble, three select bits, read/write bit; ack on match.
// - A stop after written data runs a timed write cycle, deaf meanwhile.
`default_nettype none
`include "etwsp_defines.svh"

// ************************************************************
// Two-wire serial slave port of a small serial memory.
// ************************************************************
module etwsp_slave_port #(
   parameter int unsigned P_TWR_US = `ETWSP_TWR_US
) (
   // Clock and reset.
   input  wire logic       I_SYS_CLK,
   input  wire logic       I_RSTN,
   // Two-wire bus pins.
   input  wire logic       I_SCL,
   input  wire logic       I_SDA,
   output var  logic       O_SDA_O,
   output var  logic       O_SDA_OE,
   // Strap and protect pins.
   input  wire logic [2:0] I_HW_SEL,
   input  wire logic       I_WP,
   // Received bytes towards the memory side.
   output var  logic [7:0] O_RX_DATA,
   output var  logic       O_RX_STB,
   output var  logic       O_RX_ADDR,
   // Read data from the memory side.
   output var  logic       O_TX_REQ,
   input  wire logic [7:0] I_TX_DATA,
   // Port status.
   output var  logic       O_STANDBY,
   output var  logic       O_WR_BUSY
);

   // ************************************************************
   // Timing and state.
   // ************************************************************

   // The write cycle is long, so its length is a parameter in microseconds.
   localparam logic [`ETWSP_TMR_W-1:0] TWR_CYC =
      `ETWSP_TMR_W'(P_TWR_US * `ETWSP_NS_PER_US / `ETWSP_TCLK_NS);

   etwsp_pkg::etwsp_ctl_t st_r;
   etwsp_pkg::etwsp_ctl_t st_nxt;
   logic                  addr_match;

   etwsp_line_if ln ();

   // Pin synchronisers and condition detection.
   etwsp_line_mon u_mon (
      .i_clk  (I_SYS_CLK),
      .i_rstn (I_RSTN),
      .i_scl  (I_SCL),
      .i_sda  (I_SDA),
      .i_wp   (I_WP),
      .i_sel  (I_HW_SEL),
      .ln     (ln.mon)
   );

   // Type nibble and select bits of the byte just shifted in.
   assign addr_match = (st_r.shreg[7:4] == `ETWSP_DEV_TYPE) &&
                       (st_r.shreg[3:1] == ln.sel);

   // ************************************************************
   // Byte controller.
   // ************************************************************

   // Next state: the per-state byte flow first, then bus conditions.
   always_comb begin
      st_nxt        = st_r;
      st_nxt.rx_stb = 1'h0;
      st_nxt.tx_req = 1'h0;
      unique case (st_r.state)
         // Deaf to clocks until a start is seen.
         etwsp_pkg::ST_STANDBY: begin
            st_nxt.sda_oe = 1'h0;
         end
         etwsp_pkg::ST_RX: begin
            if (ln.scl_rise) begin
               st_nxt.shreg = {st_r.shreg[6:0], ln.sda_bit};
               st_nxt.bcnt  = st_r.bcnt + 4'h1;
            end else if (ln.scl_fall && st_r.bcnt == `ETWSP_BITS) begin
               st_nxt.bcnt = 4'h0;
               if (st_r.idx == `ETWSP_IDX_ADDR) begin
                  if (addr_match) begin
                     st_nxt.state  = etwsp_pkg::ST_ACK;
                     st_nxt.sda_oe = 1'h1;
                     st_nxt.rw     = st_r.shreg[0];
                     st_nxt.tx_req = st_r.shreg[0];
                  end else begin
                     st_nxt.state = etwsp_pkg::ST_STANDBY;
                  end
               end else begin
                  st_nxt.state   = etwsp_pkg::ST_ACK;
                  st_nxt.sda_oe  = 1'h1;
                  st_nxt.rx_data = st_r.shreg;
                  st_nxt.rx_addr = (st_r.idx == `ETWSP_IDX_WORD);
                  // Protected data is still acknowledged, but never handed on.
                  st_nxt.rx_stb  = (st_r.idx == `ETWSP_IDX_WORD) || !ln.wp_lvl;
                  if (st_r.idx == `ETWSP_IDX_DATA && !ln.wp_lvl) begin
                     st_nxt.wr_pend = 1'h1;
                  end
               end
               // The index saturates, so any number of data bytes may follow.
               if (st_r.idx != `ETWSP_IDX_DATA) begin
                  st_nxt.idx = st_r.idx + 2'h1;
               end
            end
         end
         // Response bit held low until the falling edge ends the ninth clock.
         etwsp_pkg::ST_ACK: begin
            if (ln.scl_fall) begin
               st_nxt.sda_oe = 1'h0;
               if (st_r.rw) begin
                  st_nxt.state  = etwsp_pkg::ST_TX;
                  st_nxt.shreg  = I_TX_DATA;
                  st_nxt.sda_oe = ~I_TX_DATA[7];
               end else begin
                  st_nxt.state = etwsp_pkg::ST_RX;
               end
            end
         end
         // Send a byte: count on rising edges, move SDA on falling edges.
         etwsp_pkg::ST_TX: begin
            if (ln.scl_rise) begin
               st_nxt.bcnt = st_r.bcnt + 4'h1;
            end else if (ln.scl_fall) begin
               if (st_r.bcnt == `ETWSP_BITS) begin
                  st_nxt.state  = etwsp_pkg::ST_TXACK;
                  st_nxt.sda_oe = 1'h0;
                  st_nxt.bcnt   = 4'h0;
               end else begin
                  st_nxt.shreg  = {st_r.shreg[6:0], 1'h0};
                  st_nxt.sda_oe = ~st_r.shreg[6];
               end
            end
         end
         // Master response to read data, taken on the rising edge.
         etwsp_pkg::ST_TXACK: begin
            if (ln.scl_rise) begin
               if (ln.sda_bit) begin
                  st_nxt.state = etwsp_pkg::ST_STANDBY;
               end else begin
                  st_nxt.go     = 1'h1;
                  st_nxt.tx_req = 1'h1;
               end
            end else if (ln.scl_fall && st_r.go) begin
               st_nxt.go     = 1'h0;
               st_nxt.state  = etwsp_pkg::ST_TX;
               st_nxt.shreg  = I_TX_DATA;
               st_nxt.sda_oe = ~I_TX_DATA[7];
            end
         end
         // Internal write cycle: inputs ignored until the timer runs out.
         etwsp_pkg::ST_WRCYC: begin
            st_nxt.sda_oe = 1'h0;
            if (st_r.timer == '0) begin
               st_nxt.state = etwsp_pkg::ST_STANDBY;
            end else begin
               st_nxt.timer = st_r.timer - `ETWSP_TMR_W'(1);
            end
         end
         default: begin
            st_nxt.state  = etwsp_pkg::ST_STANDBY;
            st_nxt.sda_oe = 1'h0;
         end
      endcase
      // Conditions win over the byte flow, except while writing.
      if (st_r.state != etwsp_pkg::ST_WRCYC) begin
         if (ln.start_cond) begin
            st_nxt.state   = etwsp_pkg::ST_RX;
            st_nxt.bcnt    = 4'h0;
            st_nxt.idx     = `ETWSP_IDX_ADDR;
            st_nxt.sda_oe  = 1'h0;
            st_nxt.go      = 1'h0;
            st_nxt.wr_pend = 1'h0;
         end else if (ln.stop_cond) begin
            st_nxt.sda_oe  = 1'h0;
            st_nxt.go      = 1'h0;
            st_nxt.wr_pend = 1'h0;
            if (st_r.wr_pend) begin
               st_nxt.state = etwsp_pkg::ST_WRCYC;
               st_nxt.timer = TWR_CYC - `ETWSP_TMR_W'(1);
            end else begin
               st_nxt.state = etwsp_pkg::ST_STANDBY;
            end
         end
      end
      st_nxt.idle = (st_nxt.state == etwsp_pkg::ST_STANDBY);
      st_nxt.busy = (st_nxt.state == etwsp_pkg::ST_WRCYC);
   end

   // Reset lands in standby with SDA released.
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         st_r       <= '0;
         st_r.state <= etwsp_pkg::ST_STANDBY;
         st_r.idle  <= 1'h1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // Outputs.
   // ************************************************************

   // Every output is a state flop; the pin level is always low when enabled.
   assign O_SDA_O   = st_r.sda_o;
   assign O_SDA_OE  = st_r.sda_oe;
   assign O_RX_DATA = st_r.rx_data;
   assign O_RX_STB  = st_r.rx_stb;
   assign O_RX_ADDR = st_r.rx_addr;
   assign O_TX_REQ  = st_r.tx_req;
   assign O_STANDBY = st_r.idle;
   assign O_WR_BUSY = st_r.busy;

   // ************************************************************
   // Checks.
   // ************************************************************

   // Standby never drives the line.
   a_standby_quiet: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      st_r.idle |-> !O_SDA_OE)
      else $error("SDA driven in standby");

   // The enable moves only after a falling edge or a bus condition.
   a_oe_on_fall: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      $changed(O_SDA_OE) |-> $past(ln.scl_fall) || $past(ln.start_cond) ||
                             $past(ln.stop_cond))
      else $error("SDA enable changed outside SCL low");

   // A received bit is counted one cycle after the rising edge.
   a_rx_count: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      st_r.state == etwsp_pkg::ST_RX && ln.scl_rise && !ln.start_cond && !ln.stop_cond
      |=> st_r.bcnt == $past(st_r.bcnt) + 4'h1)
      else $error("received bit not counted");

   // A matching address is acknowledged on the ninth clock.
   a_addr_ack: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      st_r.state == etwsp_pkg::ST_RX && ln.scl_fall && st_r.bcnt == `ETWSP_BITS &&
      st_r.idx == `ETWSP_IDX_ADDR && addr_match && !ln.start_cond && !ln.stop_cond
      |=> O_SDA_OE && st_r.state == etwsp_pkg::ST_ACK)
      else $error("matching address not acknowledged");

   // A foreign address gets no acknowledge and the port goes quiet.
   a_addr_miss: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      st_r.state == etwsp_pkg::ST_RX && ln.scl_fall && st_r.bcnt == `ETWSP_BITS &&
      st_r.idx == `ETWSP_IDX_ADDR && !addr_match && !ln.start_cond && !ln.stop_cond
      |=> !O_SDA_OE ##1 O_STANDBY)
      else $error("foreign address answered");

   // A start outside the write cycle restarts byte reception.
   a_start_fresh: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      ln.start_cond && st_r.state != etwsp_pkg::ST_WRCYC
      |=> st_r.state == etwsp_pkg::ST_RX && st_r.bcnt == 4'h0 && !O_SDA_OE)
      else $error("start did not restart reception");

   // A plain stop reaches standby within two cycles.
   a_stop_idle: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      ln.stop_cond && !st_r.wr_pend && st_r.state != etwsp_pkg::ST_WRCYC
      |=> ##1 O_STANDBY)
      else $error("stop did not return to standby");

   // Protected data bytes never reach the memory side.
   a_wp_block: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      O_RX_STB && !O_RX_ADDR |-> !$past(ln.wp_lvl))
      else $error("data passed while write protected");

   // The acknowledge is released at the end of the ninth clock.
   a_ack_release: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      st_r.state == etwsp_pkg::ST_ACK && ln.scl_fall && !st_r.rw
      |=> !O_SDA_OE)
      else $error("acknowledge held past ninth clock");

   // A no-acknowledge to read data ends sending with SDA released.
   a_nack_stop: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      st_r.state == etwsp_pkg::ST_TXACK && ln.scl_rise && ln.sda_bit &&
      !ln.start_cond && !ln.stop_cond |=> !O_SDA_OE [*2] ##0 O_STANDBY)
      else $error("sending went on after no-acknowledge");

   // The write cycle stays deaf for its first eight cycles at least.
   a_wrcyc_deaf: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      $rose(O_WR_BUSY) |-> (O_WR_BUSY && !O_SDA_OE) [*8])
      else $error("write cycle ended early or answered");

   // Every byte after the address byte is acknowledged on the ninth clock.
   a_data_ack: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      st_r.state == etwsp_pkg::ST_RX && ln.scl_fall && st_r.bcnt == `ETWSP_BITS &&
      st_r.idx != `ETWSP_IDX_ADDR
      |=> O_SDA_OE && st_r.state == etwsp_pkg::ST_ACK)
      else $error("data byte not acknowledged");

   // The word address byte is handed on whole and flagged as an address.
   a_word_strobe: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      st_r.state == etwsp_pkg::ST_RX && ln.scl_fall && st_r.bcnt == `ETWSP_BITS &&
      st_r.idx == `ETWSP_IDX_WORD
      |=> O_RX_STB && O_RX_ADDR && O_RX_DATA == $past(st_r.shreg))
      else $error("word address byte not handed on");

   // A stop after unprotected data starts the internal write cycle.
   a_stop_write: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      ln.stop_cond && st_r.wr_pend && st_r.state != etwsp_pkg::ST_WRCYC
      |=> O_WR_BUSY && !O_STANDBY)
      else $error("write cycle not started by stop");

   // The end of the write cycle lands in standby, never in a transfer.
   a_wrcyc_done: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      $fell(O_WR_BUSY) |-> O_STANDBY)
      else $error("write cycle did not end in standby");

   // The first read bit goes out at the fall that ends the ninth clock.
   a_tx_first: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      st_r.state == etwsp_pkg::ST_ACK && ln.scl_fall && st_r.rw
      |=> O_SDA_OE == !$past(I_TX_DATA[7]))
      else $error("first read bit not driven");

   // Read data is asked for by one single-cycle pulse per byte.
   a_txreq_pulse: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
      O_TX_REQ |=> !O_TX_REQ)
      else $error("read request longer than one cycle");

endmodule

`default_nettype wire
